// ### logic/tel1_fsm.sv
// Purpose: Terminal-side layer-1 activation machine with AHB-Lite register slave
// Assumes: Receiver classifier (rx info, code-violation pulses, line level) runs on i_sys_clk
// Notes: Zero-wait-state slave; all outputs registered
`include "tel1_map.svh"
`timescale 1ns/1ps

module tel1_fsm #(
    parameter int unsigned CLKSTOP_CYCLES = `TEL1_CLKSTOP_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    input wire logic [1:0] i_rx_info,
    input wire logic i_cv_ok,
    input wire logic i_cv_lost,
    input wire logic i_line_level,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    output logic [3:0] o_ci_ind,
    output logic o_ci_change_irq,
    output logic [2:0] o_tx_info,
    output logic o_tx_pos,
    output logic o_tx_neg,
    output logic o_analog_pd,
    output logic o_if_clk_en,
    output logic o_loop_close,
    output logic o_tx_disable,
    output logic o_rx_transparent,
    output logic o_tx_transparent,
    output logic o_fsc_realign
);
    tel1_pkg::tel1_regs_t s;
    tel1_pkg::tel1_regs_t n;
    logic sw;
    logic bit_tick;
    logic unc;
    logic ar_cmd;

    assign sw = s.conf0[`TEL1_CONF0_SW_CTRL];
    assign bit_tick = (s.bit_div == 8'(`TEL1_BIT_CYC - 1));
    assign ar_cmd = (s.cmd == `TEL1_CMD_AR8) || (s.cmd == `TEL1_CMD_ACT_REQ_PRIO10);
    assign unc = (s.cmd == `TEL1_CMD_RESET) || (s.cmd == `TEL1_CMD_ARL) || (s.cmd == `TEL1_CMD_SSP) ||
        (s.cmd == `TEL1_CMD_SCP);

    // Next-state logic for bus, machine and line outputs
    always_comb begin
        n = s;
        n.realign = 1'b0;
        n.hready = 1'b1;
        // Register writes in the data phase
        if (s.wr_pend) begin
            n.wr_pend = 1'b0;
            if (s.wr_addr == `TEL1_CI_TRANSMIT_REG) begin
                n.cmd = i_hwdata[3:0];
                if (i_hwdata[3:0] == `TEL1_CMD_AR8) begin
                    n.prio10 = 1'b0;
                end else if (i_hwdata[3:0] == `TEL1_CMD_ACT_REQ_PRIO10) begin
                    n.prio10 = 1'b1;
                end
            end else if (s.wr_addr == `TEL1_INTERRUPT_STATUS_REG) begin
                if (i_hwdata[`TEL1_ISR_CI_CHANGE]) begin
                    n.irq = 1'b0;
                end
            end else if (s.wr_addr == `TEL1_TRANSCEIVER_CONFIG_0) begin
                n.conf0 = i_hwdata[2:0];
            end else if (s.wr_addr == `TEL1_TRANSCEIVER_CONFIG_2) begin
                n.tx_dis = i_hwdata[`TEL1_CONF2_TX_DISABLE];
            end else if (s.wr_addr == `TEL1_LAYER1_COMMAND_REG) begin
                n.l1cmd = i_hwdata[3:0];
            end
        end
        // Address phase capture and read data
        if (i_hsel && i_htrans[1] && i_hready) begin
            n.wr_pend = i_hwrite;
            n.wr_addr = i_haddr[7:0];
            n.hrdata = 32'h0;
            if (!i_hwrite) begin
                if (i_haddr[7:0] == `TEL1_CI_TRANSMIT_REG) begin
                    n.hrdata = {28'h0, s.cmd};
                end else if (i_haddr[7:0] == `TEL1_CI_RECEIVE_REG) begin
                    n.hrdata = {28'h0, s.ind};
                end else if (i_haddr[7:0] == `TEL1_INTERRUPT_STATUS_REG) begin
                    n.hrdata = {31'h0, s.irq};
                end else if (i_haddr[7:0] == `TEL1_TRANSCEIVER_CONFIG_0) begin
                    n.hrdata = {29'h0, s.conf0};
                end else if (i_haddr[7:0] == `TEL1_TRANSCEIVER_CONFIG_2) begin
                    n.hrdata = {31'h0, s.tx_dis};
                end else if (i_haddr[7:0] == `TEL1_LAYER1_COMMAND_REG) begin
                    n.hrdata = {28'h0, s.l1cmd};
                end else if (i_haddr[7:0] == `TEL1_LAYER1_STATUS_REG) begin
                    n.hrdata = {24'h0, 4'(s.st), 1'b0, s.frame_sync_flag, i_rx_info};
                end
            end
        end
        // Frame sync from consecutive code-violation pairs
        if (i_cv_lost) begin
            n.cv_cnt = 2'h0;
            n.frame_sync_flag = 1'b0;
        end else if (i_cv_ok && !s.frame_sync_flag) begin
            n.cv_cnt = s.cv_cnt + 2'h1;
            if (s.cv_cnt == `TEL1_CV_PAIRS_SYNC - 2'h1) begin
                n.frame_sync_flag = 1'b1;
                n.realign = 1'b1;
            end
        end
        // Activation machine, held still under software control
        if (!sw) begin
            if (unc) begin
                case (s.cmd)
                    `TEL1_CMD_RESET: n.st = tel1_pkg::UNC_RESET;
                    `TEL1_CMD_SSP: n.st = tel1_pkg::TEST_SSP;
                    `TEL1_CMD_SCP: n.st = tel1_pkg::TEST_SCP;
                    default: begin
                        if (s.st != tel1_pkg::LOOP_ACT) begin
                            n.st = tel1_pkg::LOOP_CLOSED;
                        end
                    end
                endcase
                if ((s.st == tel1_pkg::LOOP_CLOSED) && s.frame_sync_flag) begin
                    n.st = tel1_pkg::LOOP_ACT;
                end
            end else begin
                case (s.st)
                    tel1_pkg::F3_DEACT, tel1_pkg::F3_POWER_UP: begin
                        if ((s.cmd == `TEL1_CMD_DI) && (s.st == tel1_pkg::F3_POWER_UP)) begin
                            n.st = tel1_pkg::F3_DEACT;
                        end else if (i_rx_info == `TEL1_RX_INFO2) begin
                            n.st = tel1_pkg::F6_SYNC;
                        end else if (i_rx_info == `TEL1_RX_INFO4) begin
                            n.st = tel1_pkg::F7_ACT;
                        end else if (i_rx_info == `TEL1_RX_INFOX) begin
                            n.st = tel1_pkg::F5_UNSYNC;
                        end else if (ar_cmd) begin
                            n.st = tel1_pkg::F4_PEND_ACT;
                        end else if ((s.cmd == `TEL1_CMD_TIM) && (s.st == tel1_pkg::F3_DEACT)) begin
                            n.st = tel1_pkg::F3_POWER_UP;
                        end
                    end
                    tel1_pkg::F4_PEND_ACT, tel1_pkg::F5_UNSYNC: begin
                        if (s.cmd == `TEL1_CMD_DI) begin
                            n.st = tel1_pkg::F3_DEACT;
                        end else if (i_rx_info == `TEL1_RX_INFO2) begin
                            n.st = tel1_pkg::F6_SYNC;
                        end else if (i_rx_info == `TEL1_RX_INFO4) begin
                            n.st = tel1_pkg::F7_ACT;
                        end else if (i_rx_info == `TEL1_RX_INFOX) begin
                            n.st = tel1_pkg::F5_UNSYNC;
                        end else if (s.st == tel1_pkg::F5_UNSYNC) begin
                            n.st = tel1_pkg::F3_PEND_DEACT;
                        end
                    end
                    tel1_pkg::F6_SYNC, tel1_pkg::F7_ACT, tel1_pkg::F8_LOST: begin
                        if (i_rx_info == `TEL1_RX_INFO0) begin
                            n.st = tel1_pkg::F3_PEND_DEACT;
                        end else if ((s.st != tel1_pkg::F8_LOST) && s.frame_sync_flag && i_cv_lost) begin
                            n.st = tel1_pkg::F8_LOST;
                        end else if (i_rx_info == `TEL1_RX_INFO2) begin
                            n.st = tel1_pkg::F6_SYNC;
                        end else if (i_rx_info == `TEL1_RX_INFO4) begin
                            n.st = tel1_pkg::F7_ACT;
                        end
                    end
                    default: begin
                        if (s.cmd == `TEL1_CMD_DI) begin
                            n.st = tel1_pkg::F3_DEACT;
                        end
                    end
                endcase
            end
            // Power-down bit follows F3 deactivated; hardware set beats a software write
            n.l1cmd[`TEL1_L1CMD_POWER_DOWN] = (n.st == tel1_pkg::F3_DEACT);
        end
        // Indication toward the controller
        case (n.st)
            tel1_pkg::F3_PEND_DEACT: n.ind = `TEL1_IND_DR;
            tel1_pkg::F3_DEACT: n.ind = `TEL1_IND_DC;
            tel1_pkg::F3_POWER_UP, tel1_pkg::F4_PEND_ACT: n.ind = `TEL1_IND_PU;
            tel1_pkg::F6_SYNC: n.ind = `TEL1_IND_AR;
            tel1_pkg::F7_ACT: n.ind = n.prio10 ? `TEL1_IND_ACTIVATED_PRIO10_IND : `TEL1_IND_AI8;
            tel1_pkg::LOOP_CLOSED: n.ind = `TEL1_IND_ARL;
            tel1_pkg::LOOP_ACT: begin
                n.ind = (i_line_level && !n.conf0[`TEL1_CONF0_EXT_LOOP]) ? `TEL1_IND_RSY : `TEL1_IND_AIL;
            end
            tel1_pkg::UNC_RESET: n.ind = `TEL1_IND_RES;
            tel1_pkg::TEST_SSP, tel1_pkg::TEST_SCP: n.ind = `TEL1_IND_TMA;
            default: n.ind = `TEL1_IND_RSY;
        endcase
        // Change interrupt, set wins over a same-cycle clear
        if (n.ind != s.ind) begin
            n.irq = 1'b1;
        end
        // Transmitted info per state
        case (n.st)
            tel1_pkg::F4_PEND_ACT: n.tx = tel1_pkg::TX_INFO1;
            tel1_pkg::F6_SYNC, tel1_pkg::F7_ACT, tel1_pkg::LOOP_CLOSED, tel1_pkg::LOOP_ACT: begin
                n.tx = tel1_pkg::TX_INFO3;
            end
            tel1_pkg::TEST_SSP: n.tx = tel1_pkg::TX_SSP;
            tel1_pkg::TEST_SCP: n.tx = tel1_pkg::TX_SCP;
            default: n.tx = tel1_pkg::TX_INFO0;
        endcase
        if (sw) begin
            n.tx = tel1_pkg::tel1_tx_t'(n.l1cmd[2:0]);
        end
        n.apd = n.l1cmd[`TEL1_L1CMD_POWER_DOWN];
        n.loop = (n.st == tel1_pkg::LOOP_CLOSED) || (n.st == tel1_pkg::LOOP_ACT);
        n.txd = n.loop && n.tx_dis;
        n.rx_tr = (n.st == tel1_pkg::F7_ACT) || (n.st == tel1_pkg::LOOP_ACT);
        n.tx_tr = n.rx_tr && n.frame_sync_flag && ((n.cmd == `TEL1_CMD_AR8) || (n.cmd == `TEL1_CMD_ACT_REQ_PRIO10) ||
            (n.cmd == `TEL1_CMD_ARL));
        // Clock stop after a quiet spell in F3 deactivated
        if ((n.st == tel1_pkg::F3_DEACT) && (s.st == tel1_pkg::F3_DEACT) && !sw &&
            !s.conf0[`TEL1_CONF0_CLK_STOP_CFG] && (i_rx_info == `TEL1_RX_INFO0)) begin
            if (s.stop_cnt == 14'(CLKSTOP_CYCLES - 1)) begin
                n.clk_en = 1'b0;
            end else begin
                n.stop_cnt = s.stop_cnt + 14'h1;
            end
        end else begin
            n.stop_cnt = 14'h0;
            n.clk_en = 1'b1;
        end
        // Bit clock and test pulse patterns
        n.bit_div = bit_tick ? 8'h0 : s.bit_div + 8'h1;
        if (bit_tick) begin
            n.bit_idx = (s.bit_idx == `TEL1_BITS_PER_FRAME - 6'h1) ? 6'h0 : s.bit_idx + 6'h1;
            n.tx_pos = 1'b0;
            n.tx_neg = 1'b0;
            if ((s.tx == tel1_pkg::TX_SCP) || ((s.tx == tel1_pkg::TX_SSP) && (s.bit_idx == 6'h0))) begin
                n.tx_pos = !s.pol;
                n.tx_neg = s.pol;
                n.pol = !s.pol;
            end
        end
    end

    // State register with synchronous reset
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            s <= '0;
            s.st <= tel1_pkg::F3_DEACT;
            s.cmd <= `TEL1_CMD_RESET_VAL;
            s.l1cmd <= 4'h8;
            s.ind <= `TEL1_IND_DC;
            s.clk_en <= 1'b1;
            s.apd <= 1'b1;
            s.hready <= 1'b1;
            s.st <= tel1_pkg::F3_DEACT;
        end else begin
            s <= n;
        end
    end

    assign o_hreadyout = s.hready;
    assign o_hresp = 1'b0 & s.hready;
    assign o_hrdata = s.hrdata;
    assign o_ci_ind = s.ind;
    assign o_ci_change_irq = s.irq;
    assign o_tx_info = s.tx;
    assign o_tx_pos = s.tx_pos;
    assign o_tx_neg = s.tx_neg;
    assign o_analog_pd = s.apd;
    assign o_if_clk_en = s.clk_en;
    assign o_loop_close = s.loop;
    assign o_tx_disable = s.txd;
    assign o_rx_transparent = s.rx_tr;
    assign o_tx_transparent = s.tx_tr;
    assign o_fsc_realign = s.realign;

    // Checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    reset_f3d_dc_a: assert property ($rose(i_rst_n) |-> s.st == tel1_pkg::F3_DEACT && o_ci_ind == 4'hf)
        else $error("Reset does not land in F3 deactivated with confirmation");
    f3d_info0_a: assert property (s.st == tel1_pkg::F3_DEACT && !sw |->
        o_tx_info == 3'(tel1_pkg::TX_INFO0) && o_ci_ind == `TEL1_IND_DC)
        else $error("F3 deactivated not sending info 0 with confirmation");
    unc_reset_a: assert property (!sw && s.cmd == `TEL1_CMD_RESET |=> s.st == tel1_pkg::UNC_RESET)
        else $error("Reset command ignored");
    f3d_timing_a: assert property (!sw && !unc && s.st == tel1_pkg::F3_DEACT &&
        s.cmd == `TEL1_CMD_TIM && i_rx_info == `TEL1_RX_INFO0 |=> s.st == tel1_pkg::F3_POWER_UP)
        else $error("Timing command did not power up");
    pd_entry_a: assert property (!sw && s.st != tel1_pkg::F3_DEACT ##1 s.st == tel1_pkg::F3_DEACT |->
        s.l1cmd[`TEL1_L1CMD_POWER_DOWN] && o_analog_pd)
        else $error("Power-down not set on entry to F3 deactivated");
    f4_info1_a: assert property (!sw && s.st == tel1_pkg::F4_PEND_ACT |-> o_tx_info == 3'(tel1_pkg::TX_INFO1))
        else $error("F4 not sending info 1");
    loss_f8_a: assert property (!sw && !unc && (s.st == tel1_pkg::F6_SYNC || s.st == tel1_pkg::F7_ACT) &&
        s.frame_sync_flag && i_cv_lost && i_rx_info != `TEL1_RX_INFO0 |=> s.st == tel1_pkg::F8_LOST)
        else $error("Sync loss did not enter F8");
    sync_three_a: assert property ($rose(s.frame_sync_flag) |-> o_fsc_realign && $past(i_cv_ok) && $past(s.cv_cnt) == 2'h2)
        else $error("Frame sync without three valid pairs");
    irq_change_a: assert property (o_ci_ind != $past(o_ci_ind) |-> o_ci_change_irq)
        else $error("Indication changed without interrupt");
    tx_transp_a: assert property (o_tx_transparent |-> o_rx_transparent && s.frame_sync_flag)
        else $error("Transmit transparency without sync and activation");
    clk_stop_a: assert property ($fell(o_if_clk_en) |-> $past(s.st) == tel1_pkg::F3_DEACT &&
        !$past(s.conf0[`TEL1_CONF0_CLK_STOP_CFG]))
        else $error("Clocks stopped outside F3 deactivated");
    ahb_okay_a: assert property (o_hreadyout && !o_hresp)
        else $error("Slave not ready or not OKAY");

    // Software control freezes the machine
    sw_freeze_a: assert property (sw |=> $stable(s.st))
        else $error("State moved under software control");
    // Activation request from F3 deactivated on a quiet line
    ar_f4_a: assert property (!sw && !unc && s.st == tel1_pkg::F3_DEACT && ar_cmd &&
        i_rx_info == `TEL1_RX_INFO0 |=> s.st == tel1_pkg::F4_PEND_ACT)
        else $error("Activation request did not reach F4");
    // Without an unconditional command, pending deactivation only leaves on the deactivation command
    pend_stay_a: assert property (!sw && !unc && s.st == tel1_pkg::F3_PEND_DEACT &&
        s.cmd != `TEL1_CMD_DI |=> s.st == tel1_pkg::F3_PEND_DEACT)
        else $error("Pending deactivation left without command");
    // Unknown line signal in F4 or F5 leads to F5
    infox_f5_a: assert property (!sw && !unc && s.cmd != `TEL1_CMD_DI &&
        (s.st == tel1_pkg::F4_PEND_ACT || s.st == tel1_pkg::F5_UNSYNC) &&
        i_rx_info == `TEL1_RX_INFOX |=> s.st == tel1_pkg::F5_UNSYNC)
        else $error("Unknown line signal did not give F5");
    // F6 answers with info 3
    f6_info3_a: assert property (!sw && s.st == tel1_pkg::F6_SYNC |->
        o_tx_info == 3'(tel1_pkg::TX_INFO3))
        else $error("F6 not sending info 3");
    // F7 passes receive channels through
    f7_rx_tr_a: assert property (s.st == tel1_pkg::F7_ACT |-> o_rx_transparent)
        else $error("F7 without receive transparency");
    // Loop A closes the loop and sends info 3
    loop_info3_a: assert property (!sw && s.st == tel1_pkg::LOOP_CLOSED |->
        o_loop_close && o_tx_info == 3'(tel1_pkg::TX_INFO3))
        else $error("Loop A closed without loop or info 3");
    // Test pulses never drive both polarities
    pulse_pol_a: assert property (!(o_tx_pos && o_tx_neg))
        else $error("Both pulse polarities at once");
    // Realign is a single-cycle pulse
    realign_once_a: assert property (o_fsc_realign |=> !o_fsc_realign)
        else $error("Realign pulse longer than one cycle");

    reach_f7_c: cover property (s.st == tel1_pkg::F7_ACT && o_tx_transparent);
    reach_loop_c: cover property (s.st == tel1_pkg::LOOP_ACT);
    reach_scp_c: cover property (s.st == tel1_pkg::TEST_SCP && o_tx_pos);
    clk_stop_c: cover property ($fell(o_if_clk_en));
    reach_f8_c: cover property (s.st == tel1_pkg::F8_LOST);
endmodule : tel1_fsm

// ### logic/tel1_map.svh
// Purpose: Offsets, field positions, codes and timing for the terminal layer-1 activation machine
// Assumes: 32-bit AHB-Lite register words, 25 MHz system clock
// Notes: Definitions only
`ifndef TEL1_MAP_SVH
`define TEL1_MAP_SVH

// Register byte offsets
`define TEL1_CI_TRANSMIT_REG 8'h00
`define TEL1_CI_RECEIVE_REG 8'h04
`define TEL1_INTERRUPT_STATUS_REG 8'h08
`define TEL1_TRANSCEIVER_CONFIG_0 8'h0c
`define TEL1_TRANSCEIVER_CONFIG_2 8'h10
`define TEL1_LAYER1_COMMAND_REG 8'h14
`define TEL1_LAYER1_STATUS_REG 8'h18

// Field positions
`define TEL1_CONF0_SW_CTRL 0
`define TEL1_CONF0_CLK_STOP_CFG 1
`define TEL1_CONF0_EXT_LOOP 2
`define TEL1_CONF2_TX_DISABLE 0
`define TEL1_L1CMD_POWER_DOWN 3
`define TEL1_ISR_CI_CHANGE 0
`define TEL1_STA_FRAME_SYNC_FLAG 2

// Commands toward layer 1
`define TEL1_CMD_TIM 4'h0
`define TEL1_CMD_RESET 4'h1
`define TEL1_CMD_SSP 4'h2
`define TEL1_CMD_SCP 4'h3
`define TEL1_CMD_AR8 4'h8
`define TEL1_CMD_ACT_REQ_PRIO10 4'h9
`define TEL1_CMD_ARL 4'ha
`define TEL1_CMD_DI 4'hf

// Indications from layer 1
`define TEL1_IND_DR 4'h0
`define TEL1_IND_RES 4'h1
`define TEL1_IND_TMA 4'h2
`define TEL1_IND_RSY 4'h4
`define TEL1_IND_PU 4'h7
`define TEL1_IND_AR 4'h8
`define TEL1_IND_ARL 4'ha
`define TEL1_IND_AI8 4'hc
`define TEL1_IND_ACTIVATED_PRIO10_IND 4'hd
`define TEL1_IND_AIL 4'he
`define TEL1_IND_DC 4'hf

// Received line info codes
`define TEL1_RX_INFO0 2'h0
`define TEL1_RX_INFO2 2'h1
`define TEL1_RX_INFO4 2'h2
`define TEL1_RX_INFOX 2'h3

// Reset values and sync pair threshold
`define TEL1_CMD_RESET_VAL 4'h1
`define TEL1_CV_PAIRS_SYNC 2'h3

// Timing
`define TEL1_SYS_HZ 25000000
`define TEL1_BIT_HZ 192000
`define TEL1_BIT_CYC (`TEL1_SYS_HZ / `TEL1_BIT_HZ)
`define TEL1_BITS_PER_FRAME 6'h30
`define TEL1_CLKSTOP_US 500
`define TEL1_CLKSTOP_CYC ((`TEL1_CLKSTOP_US * (`TEL1_SYS_HZ / 1000)) / 1000)

`endif

// ### logic/tel1_pkg.sv
// Purpose: Types for the terminal layer-1 activation machine
// Assumes: Used through tel1_pkg:: names only
// Notes: Encodings follow declaration order from zero
package tel1_pkg;
    typedef enum logic [3:0] {
        F3_PEND_DEACT, F3_DEACT, F3_POWER_UP, F4_PEND_ACT, F5_UNSYNC, F6_SYNC, F7_ACT, F8_LOST,
        LOOP_CLOSED, LOOP_ACT, UNC_RESET, TEST_SSP, TEST_SCP
    } tel1_state_t;

    typedef enum logic [2:0] {
        TX_INFO0, TX_INFO1, TX_INFO3, TX_SSP, TX_SCP
    } tel1_tx_t;

    typedef struct packed {
        tel1_state_t st;
        logic [3:0] cmd;
        logic prio10;
        logic [2:0] conf0;
        logic tx_dis;
        logic [3:0] l1cmd;
        logic [3:0] ind;
        logic irq;
        logic frame_sync_flag;
        logic [1:0] cv_cnt;
        logic [13:0] stop_cnt;
        logic clk_en;
        logic realign;
        logic [7:0] bit_div;
        logic [5:0] bit_idx;
        logic pol;
        logic tx_pos;
        logic tx_neg;
        tel1_tx_t tx;
        logic apd;
        logic rx_tr;
        logic tx_tr;
        logic loop;
        logic txd;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] hrdata;
        logic hready;
    } tel1_regs_t;
endpackage : tel1_pkg

// ### verif/tel1_line_model.sv
// Purpose: Line receiver model feeding the activation machine
// Assumes: Bench commands the received info and frame sync
// Notes: One code-violation pair every 8 clocks while sync is on
`include "tel1_map.svh"
`timescale 1ns/1ps
module tel1_line_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [1:0] i_info,
    input wire logic i_sync,
    input wire logic i_lose,
    output logic [1:0] o_rx_info,
    output logic o_cv_ok,
    output logic o_cv_lost,
    output logic o_level
);
    logic [2:0] div;
    // Classify the line and pace the code-violation pairs
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            {o_rx_info, o_cv_ok, o_cv_lost, o_level, div} <= '0;
        end else begin
            o_rx_info <= i_info;
            o_level <= (i_info != `TEL1_RX_INFO0);
            div <= div + 3'h1;
            o_cv_ok <= i_sync && (div == 3'h0);
            o_cv_lost <= i_lose;
        end
    end
endmodule : tel1_line_model

// ### verif/te_layer1_activation_fsm_bench.sv
// Purpose: Self-checking bench for the layer-1 activation machine
// Assumes: Zero-wait AHB-Lite slave, clock-stop count shortened to 20
// Notes: Outputs are sampled at the edge, before that edge's updates
`include "tel1_map.svh"
`timescale 1ns/1ps
module te_layer1_activation_fsm_bench;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, sync = 1'b0, lose = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, rd;
    logic [1:0] htrans = 2'h0, info = 2'h0, rx_info;
    logic cv_ok, cv_lost, level, hready, irq, pd, clk_en, lp, rx_tr, tx_tr;
    logic pos, neg, txd, hresp, realign, seen_rl = 1'b0;
    logic [31:0] hrdata;
    logic [3:0] ind;
    logic [2:0] tx;
    int err_total = 0, compares = 0;
    // Clock
    always #20 clk = ~clk;
    // Remember the one-cycle frame-sync realign pulse
    always @(posedge clk) begin
        if (realign) seen_rl <= 1'b1;
    end
    tel1_line_model line (.i_clk(clk), .i_rst_n(rst_n), .i_info(info), .i_sync(sync), .i_lose(lose),
        .o_rx_info(rx_info), .o_cv_ok(cv_ok), .o_cv_lost(cv_lost), .o_level(level));
    tel1_fsm #(.CLKSTOP_CYCLES(20)) uut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
        .i_rx_info(rx_info), .i_cv_ok(cv_ok), .i_cv_lost(cv_lost), .i_line_level(level),
        .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata), .o_ci_ind(ind), .o_ci_change_irq(irq),
        .o_tx_info(tx), .o_tx_pos(pos), .o_tx_neg(neg), .o_analog_pd(pd), .o_if_clk_en(clk_en),
        .o_loop_close(lp), .o_tx_disable(txd), .o_rx_transparent(rx_tr), .o_tx_transparent(tx_tr),
        .o_fsc_realign(realign));
    task final_report;
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            final_report;
        end
    endtask : wait_ready
    // One single word transfer: address phase, then data phase
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_ready;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready;
        rd = hrdata;
    endtask : bus
    task cmd(input logic [3:0] c);
        bus(1'b1, `TEL1_CI_TRANSMIT_REG, {28'h0, c});
        repeat (2) @(posedge clk);
    endtask : cmd
    task t_reset;
        repeat (5) @(posedge clk);
        chk(ind, 4'hf);
        chk(pd, 1'b1);
        rst_n <= 1'b1;
        cmd(`TEL1_CMD_DI);
        chk({tx, ind}, {3'h0, 4'hf});
        bus(1'b0, `TEL1_LAYER1_STATUS_REG, 32'h0);
        chk(rd[7:4], 4'h1);
        chk(hresp, 1'b0);
        $display("test reset done");
    endtask : t_reset
    task t_activate;
        info <= `TEL1_RX_INFOX;
        repeat (3) @(posedge clk);
        chk(ind, 4'h4);
        info <= `TEL1_RX_INFO0;
        repeat (3) @(posedge clk);
        cmd(`TEL1_CMD_DI);
        bus(1'b1, `TEL1_INTERRUPT_STATUS_REG, 32'h1);
        cmd(`TEL1_CMD_AR8);
        chk({tx, ind}, {3'h1, 4'h7});
        bus(1'b0, `TEL1_INTERRUPT_STATUS_REG, 32'h0);
        chk(rd, 32'h1);
        info <= `TEL1_RX_INFO2;
        repeat (3) @(posedge clk);
        chk({tx, ind}, {3'h2, 4'h8});
        info <= `TEL1_RX_INFO4;
        sync <= 1'b1;
        repeat (40) @(posedge clk);
        chk({ind, rx_tr, tx_tr}, {4'hc, 2'h3});
        bus(1'b0, `TEL1_LAYER1_STATUS_REG, 32'h0);
        chk(rd[2], 1'b1);
        chk(seen_rl, 1'b1);
        lose <= 1'b1;
        @(posedge clk);
        lose <= 1'b0;
        repeat (2) @(posedge clk);
        chk(ind, 4'h4);
        $display("test activate done");
    endtask : t_activate
    task t_uncond;
        logic [3:0] cs [4] = '{`TEL1_CMD_SSP, `TEL1_CMD_SCP, `TEL1_CMD_RESET, `TEL1_CMD_ARL};
        logic [7:0] ex [4] = '{8'h32, 8'h42, 8'h01, 8'h2a};
        for (int i = 0; i < 4; i++) begin
            cmd(cs[i]);
            chk({1'b0, tx, ind}, ex[i]);
            if (i == 1) begin
                repeat (135) @(posedge clk);
                chk(pos ^ neg, 1'b1);
            end
        end
        chk(lp, 1'b1);
        chk(txd, 1'b0);
        $display("test unconditional done");
    endtask : t_uncond
    task t_clkstop;
        info <= `TEL1_RX_INFO0;
        sync <= 1'b0;
        cmd(`TEL1_CMD_DI);
        chk({ind, pd, clk_en}, {4'hf, 2'h3});
        repeat (25) @(posedge clk);
        chk(clk_en, 1'b0);
        $display("test clock stop done");
    endtask : t_clkstop
    task t_soft;
        bus(1'b1, `TEL1_TRANSCEIVER_CONFIG_0, 32'h1);
        bus(1'b1, `TEL1_LAYER1_COMMAND_REG, 32'h1);
        repeat (2) @(posedge clk);
        chk(tx, 3'h1);
        bus(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        $display("test software control done");
    endtask : t_soft
    initial begin
        t_reset;
        t_activate;
        t_uncond;
        t_clkstop;
        t_soft;
        final_report;
    end
endmodule : te_layer1_activation_fsm_bench
